// *** src/itc_pkg.sv ***
// Package with register map, field positions and reset values for integration test control.
// Behaviour
// - Bit 0 selects integration mode; reset 0 keeps functional mode.
// - With bit 0 set, bit 1 enables RAM drive or read; reset 0 leaves RAM untouched.
// - Bit 2 selects write or read of the indexed walk-cache or buffer-unit RAM entry.
// - Bit 3 targets control-unit RAMs at 0, buffer-unit RAMs at 1.
// - With control unit targeted, bits 8:5 ignored; bit 4 picks the RAM.
// - One bit 4 value selects translation/prefetch RAM, direction from fault syndrome flag.
// - Other bit 4 value selects walk-cache RAM, direction from write-not-read flag.
// - With buffer unit targeted, field gives unit number; only log2 count bits valid.
// - Test input bit 0 returns the synchronised secure debug enable pin level.
// - Control register bits 31:9 are reserved with no function.
// - With RAM drive off, index register means buffer-unit performance interrupt data.
`default_nettype none

package itc_pkg;
   localparam logic [7:0]  ITC_OFF_CONTROL  = 8'h00;
   localparam logic [7:0]  ITC_OFF_TEST_IN  = 8'h04;
   localparam logic [7:0]  ITC_OFF_INDEX    = 8'h08;
   localparam logic [7:0]  ITC_OFF_STATUS   = 8'h0C;
   localparam int          ITC_BIT_INTG     = 0;
   localparam int          ITC_BIT_RAM      = 1;
   localparam int          ITC_BIT_WNR      = 2;
   localparam int          ITC_BIT_UNIT     = 3;
   localparam int          ITC_TGT_LO       = 4;
   localparam int          ITC_TGT_HI       = 8;
   localparam logic [8:0]  ITC_CONTROL_RST  = 9'h000;
   localparam logic [31:0] ITC_INDEX_RST    = 32'h0000_0000;
   localparam logic        ITC_WALK_CACHE_SEL = 1'b1;

   typedef enum logic [1:0] {
      ITC_RAM_NONE,
      ITC_RAM_XLATE,
      ITC_RAM_WALK,
      ITC_RAM_BUFFER
   } itc_ram_t;
endpackage : itc_pkg

`default_nettype wire

// *** src/itc_sync.sv ***
// Two flip-flop synchroniser for one pin level.
`default_nettype none

module itc_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb begin
      next_meta = rst_i ? 1'b0 : (ce_i ? d_i : meta);
      next_q    = rst_i ? 1'b0 : (ce_i ? meta : q_o);
   end

   always_ff @(posedge clk_i) begin
      meta <= next_meta;
      q_o  <= next_q;
   end
endmodule : itc_sync

`default_nettype wire

// *** src/itc_decode.sv ***
// Decode of the integration control bits into a RAM target selection.
`default_nettype none

module itc_decode
   import itc_pkg::*;
#(
   parameter int UNIT_BITS = 5
) (
   input  wire logic [8:0]           control_i,
   output itc_ram_t                  ram_o,
   output logic [UNIT_BITS-1:0]      unit_o
);
   always_comb begin
      ram_o  = ITC_RAM_NONE;
      unit_o = '0;
      if (control_i[ITC_BIT_INTG] && control_i[ITC_BIT_RAM]) begin
         if (control_i[ITC_BIT_UNIT]) begin
            ram_o  = ITC_RAM_BUFFER;
            unit_o = control_i[ITC_TGT_LO +: UNIT_BITS];
         end else if (control_i[ITC_TGT_LO] == ITC_WALK_CACHE_SEL) begin
            ram_o = ITC_RAM_WALK;
         end else begin
            ram_o = ITC_RAM_XLATE;
         end
      end
   end
endmodule : itc_decode

`default_nettype wire

// *** src/itc_top.sv ***
// Integration test control registers with a classic Wishbone slave.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`default_nettype none

module itc_top
   import itc_pkg::*;
#(
   parameter int UNIT_BITS = 5
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 secure_debug_en_i,
   input  wire logic                 xlate_wnr_i,
   output logic                      integration_o,
   output logic                      ram_drive_o,
   output logic                      ram_write_o,
   output logic                      xlate_ram_sel_o,
   output logic                      walk_cache_ram_o,
   output logic                      buffer_ram_sel_o,
   output logic [UNIT_BITS-1:0]      buffer_unit_o,
   output logic [31:0]               ram_index_o,
   output logic [31:0]               perf_irq_info_o
);
   logic [8:0]           control;
   logic [8:0]           next_control;
   logic [31:0]          index;
   logic [31:0]          next_index;
   logic [31:0]          next_dat;
   logic                 next_ack;
   logic                 pin_level;
   logic                 wnr_sync;
   itc_ram_t             ram_sel;
   logic [UNIT_BITS-1:0] unit_sel;
   logic                 next_integ;
   logic                 next_drive;
   logic                 next_write;
   logic                 next_xlate;
   logic                 next_walk;
   logic                 next_buf;
   logic [UNIT_BITS-1:0] next_unit;
   logic [31:0]          next_ram_index;
   logic [31:0]          next_perf;
   logic                 wr_fire;

   itc_sync u_pin_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (secure_debug_en_i),
      .q_o   (pin_level)
   );

   // The syndrome flag comes from logic elsewhere and may sit in another domain.
   itc_sync u_wnr_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (xlate_wnr_i),
      .q_o   (wnr_sync)
   );

   itc_decode #(
      .UNIT_BITS (UNIT_BITS)
   ) u_decode (
      .control_i (control),
      .ram_o     (ram_sel),
      .unit_o    (unit_sel)
   );

   // The ack drops for a cycle after each answer, so one request gives one write.
   assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   // Writes are taken at any time; keeping them to the disabled state is software's duty.
   always_comb begin
      next_control = control;
      next_index   = index;
      if (wr_fire && wb_adr_i == ITC_OFF_CONTROL) begin
         if (wb_sel_i[0]) begin
            next_control[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            next_control[8] = wb_dat_i[8];
         end
      end
      if (wr_fire && wb_adr_i == ITC_OFF_INDEX) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               next_index[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
         end
      end
      if (rst_i) begin
         next_control = ITC_CONTROL_RST;
         next_index   = ITC_INDEX_RST;
      end
   end

   always_comb begin
      next_ack = 1'b0;
      next_dat = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         next_ack = 1'b1;
         case (wb_adr_i)
            ITC_OFF_CONTROL: next_dat = {23'h000000, control};
            ITC_OFF_TEST_IN: next_dat = {31'h00000000, pin_level};
            ITC_OFF_INDEX:   next_dat = index;
            ITC_OFF_STATUS:  next_dat = {29'h00000000, wnr_sync, ram_sel};
            default:         next_dat = 32'h0000_0000;
         endcase
      end
      if (rst_i) begin
         next_ack = 1'b0;
         next_dat = 32'h0000_0000;
      end
   end

   always_comb begin
      next_integ     = control[ITC_BIT_INTG];
      next_drive     = (ram_sel != ITC_RAM_NONE);
      next_xlate     = (ram_sel == ITC_RAM_XLATE);
      next_walk      = (ram_sel == ITC_RAM_WALK);
      next_buf       = (ram_sel == ITC_RAM_BUFFER);
      next_unit      = unit_sel;
      next_write     = 1'b0;
      next_ram_index = 32'h0000_0000;
      next_perf      = 32'h0000_0000;
      case (ram_sel)
         ITC_RAM_XLATE:  next_write = wnr_sync;
         ITC_RAM_WALK:   next_write = control[ITC_BIT_WNR];
         ITC_RAM_BUFFER: next_write = control[ITC_BIT_WNR];
         default:        next_write = 1'b0;
      endcase
      if (next_drive) begin
         next_ram_index = index;
      end else begin
         next_perf = index;
      end
      if (rst_i) begin
         next_integ     = 1'b0;
         next_drive     = 1'b0;
         next_xlate     = 1'b0;
         next_walk      = 1'b0;
         next_buf       = 1'b0;
         next_unit      = '0;
         next_write     = 1'b0;
         next_ram_index = 32'h0000_0000;
         next_perf      = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i || rst_i) begin
         control          <= next_control;
         index            <= next_index;
         wb_ack_o         <= next_ack;
         wb_dat_o         <= next_dat;
         integration_o    <= next_integ;
         ram_drive_o      <= next_drive;
         ram_write_o      <= next_write;
         xlate_ram_sel_o  <= next_xlate;
         walk_cache_ram_o <= next_walk;
         buffer_ram_sel_o <= next_buf;
         buffer_unit_o    <= next_unit;
         ram_index_o      <= next_ram_index;
         perf_irq_info_o  <= next_perf;
      end
   end
endmodule : itc_top

`default_nettype wire

// *** bench/itc_top_assertions.sv ***
// Port-level checker for the integration test control block.
`default_nettype none
module itc_chk
   import itc_pkg::*;
#(
   parameter int UNIT_BITS = 5
) (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 ce_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 integration_o,
   input wire logic                 ram_drive_o,
   input wire logic                 xlate_ram_sel_o,
   input wire logic                 walk_cache_ram_o,
   input wire logic                 buffer_ram_sel_o,
   input wire logic [UNIT_BITS-1:0] buffer_unit_o,
   input wire logic [31:0]          ram_index_o,
   input wire logic [31:0]          perf_irq_info_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_wr_ctl;
      s_req ##0 (wb_we_i && wb_adr_i == ITC_OFF_CONTROL && wb_sel_i[0]);
   endsequence
   a_intg_follow: assert property (s_wr_ctl |-> ##2 integration_o == $past(wb_dat_i[0], 2))
      else $error("integration output does not follow the written bit");
   a_drive_gate: assert property ((xlate_ram_sel_o || walk_cache_ram_o || buffer_ram_sel_o) |-> ram_drive_o && integration_o)
      else $error("RAM selected without integration and drive");
   a_sel_onehot: assert property ($onehot0({xlate_ram_sel_o, walk_cache_ram_o, buffer_ram_sel_o}))
      else $error("more than one RAM target selected");
   a_walk_select: assert property (s_wr_ctl ##0 (wb_dat_i[1:0] == 2'h3 && !wb_dat_i[3] && wb_dat_i[4] == ITC_WALK_CACHE_SEL) |-> ##2 walk_cache_ram_o)
      else $error("walk cache RAM not selected");
   a_unit_idle: assert property (!buffer_ram_sel_o |-> buffer_unit_o == '0)
      else $error("buffer unit number shown without buffer target");
   a_test_rsvd: assert property (s_req ##0 (!wb_we_i && wb_adr_i == ITC_OFF_TEST_IN) |=> wb_dat_o[31:1] == 31'h0)
      else $error("test input reserved bits not zero");
   a_ctl_rsvd: assert property (s_req ##0 (!wb_we_i && wb_adr_i == ITC_OFF_CONTROL) |=> wb_dat_o[31:9] == 23'h0)
      else $error("control reserved bits not zero");
   a_index_split: assert property (ram_drive_o ? perf_irq_info_o == 32'h0 : ram_index_o == 32'h0)
      else $error("index shown on the wrong output");
endmodule : itc_chk
bind itc_top itc_chk #(.UNIT_BITS(UNIT_BITS)) u_chk (.*);
`default_nettype wire

// *** bench/tb_itc_top.sv ***
// Self-checking bench for the integration test control registers.
`default_nettype none
module tb_itc_top
   import itc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, secure_debug_en_i = 1'b0, xlate_wnr_i = 1'b0, en;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [8:0]  c;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, ram_index_o, perf_irq_info_o, rnd = 32'hC48F;
   logic        wb_ack_o, integration_o, ram_drive_o, ram_write_o, xlate_ram_sel_o;
   logic        walk_cache_ram_o, buffer_ram_sel_o;
   logic [4:0]  buffer_unit_o;
   logic [31:0] exp_q[$];
   int          bad_count = 0, cmp_count = 0;
   always #5 clk_i = ~clk_i;
   itc_top dut (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   // Entered just after a rising edge; waits for ack without assuming its latency.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, 4'hF};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         cmp(wb_dat_o, exp_q.pop_front(), "read");
      end
   end
   task automatic summarize();
      $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ITC_OFF_CONTROL, 32'h0);
      rd(ITC_OFF_INDEX, ITC_INDEX_RST);
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         c = rnd[8:0] | ((i % 3 != 0) ? 9'h003 : 9'h000);
         en = c[0] & c[1];
         xlate_wnr_i <= rnd[9];
         secure_debug_en_i <= rnd[10];
         bus(1'b1, ITC_OFF_INDEX, rnd);
         // Reserved bits carry random junk so that a leak into readback shows.
         bus(1'b1, ITC_OFF_CONTROL, {rnd[31:9], c});
         repeat (3) @(posedge clk_i);
         rd(ITC_OFF_CONTROL, {23'h0, c});
         rd(ITC_OFF_TEST_IN, {31'h0, rnd[10]});
         rd(ITC_OFF_STATUS, {29'h0, rnd[9], en ? (c[3] ? 2'h3 :
            ((c[4] == ITC_WALK_CACHE_SEL) ? 2'h2 : 2'h1)) : 2'h0});
         cmp({integration_o, ram_drive_o, xlate_ram_sel_o, walk_cache_ram_o, buffer_ram_sel_o},
             {c[0], en, en & !c[3] & (c[4] != ITC_WALK_CACHE_SEL),
              en & !c[3] & (c[4] == ITC_WALK_CACHE_SEL), en & c[3]}, "mode");
         if (en) cmp(ram_write_o, (!c[3] && c[4] != ITC_WALK_CACHE_SEL) ? rnd[9] : c[2], "dir");
         if (en & c[3]) cmp(buffer_unit_o, c[8:4], "unit");
         cmp({ram_index_o, perf_irq_info_o}, en ? {rnd, 32'h0} : {32'h0, rnd}, "index");
      end
      bus(1'b1, ITC_OFF_TEST_IN, 32'hFFFF_FFFF);
      rd(ITC_OFF_TEST_IN, {31'h0, rnd[10]});
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0);
      // A frozen enable must hold the synchroniser, so the new pin level shows only after it runs.
      ce_i <= 1'b0;
      secure_debug_en_i <= ~rnd[10];
      repeat (4) @(posedge clk_i);
      cmp({ram_index_o, perf_irq_info_o}, en ? {rnd, 32'h0} : {32'h0, rnd}, "freeze");
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(ITC_OFF_TEST_IN, {31'h0, ~rnd[10]});
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ITC_OFF_CONTROL, 32'h0);
      cmp(integration_o, 1'b0, "intg");
      summarize();
   end
endmodule : tb_itc_top
`default_nettype wire
